// ===== hw/mnsc_pkg.sv
// constants and types shared by the multiply/negate/stack/call execution block
package mnsc_pkg;
  // -------------------------------------------------------------------------
  // opcode fields
  // -------------------------------------------------------------------------
  localparam logic [7:0]  MULLIT_HI    = 8'h0D;
  localparam logic [6:0]  MULFILE_HI7  = 7'h01;
  localparam logic [6:0]  NEGATE_HI7   = 7'h36;
  localparam logic [4:0]  CALL_REL_HI5 = 5'h1B;
  localparam logic [15:0] POP_OPC      = 16'h0006;
  localparam logic [15:0] PUSH_OPC     = 16'h0005;
  localparam logic [15:0] SWRST_OPC    = 16'h00FF;
  localparam logic [15:0] NOP_OPC      = 16'h0000;
  localparam logic [3:0]  NOP2_HI4     = 4'hF;
  localparam int          ACC_BIT      = 8;
  localparam int          OFS_W        = 11;
  // -------------------------------------------------------------------------
  // addressing
  // -------------------------------------------------------------------------
  localparam logic [7:0]  IDX_LIMIT    = 8'h5F;
  localparam logic [7:0]  ACC_SPLIT    = 8'h60;
  localparam logic [3:0]  ACC_HI_BANK  = 4'h0;
  localparam logic [3:0]  SFR_BANK     = 4'hF;
  localparam logic [20:0] PC_STEP      = 21'h000002;
  localparam logic [20:0] PC_RESET     = 21'h000000;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [4:0]  SP_ZERO      = 5'h00;
  localparam logic [4:0]  SP_ONE       = 5'h01;
  localparam logic [4:0]  SP_MAX       = 5'h1F;
  localparam int          STK_DEPTH    = 31;
  // status flag positions
  localparam int          FLG_C        = 0;
  localparam int          FLG_DC       = 1;
  localparam int          FLG_Z        = 2;
  localparam int          FLG_OV       = 3;
  localparam int          FLG_N        = 4;
  localparam logic [4:0]  STATUS_RESET = 5'h00;

  typedef enum logic [2:0] {
    MNSC_EXEC_ST  = 3'b001,
    MNSC_FLUSH_ST = 3'b010,
    MNSC_RST_ST   = 3'b100
  } mnsc_state_type;
endpackage

// ===== hw/mnsc_stack_mem.sv
// return-stack storage with registered read data
module mnsc_stack_mem
  import mnsc_pkg::*;
(
  // clock
  input  wire logic        sys_clk_i,
  // write port
  input  wire logic        wr_en_i,
  input  wire logic [4:0]  wr_addr_i,
  input  wire logic [20:0] wr_data_i,
  // read port
  input  wire logic [4:0]  rd_addr_i,
  output logic      [20:0] rd_data_o
);
  logic [20:0] mem_ff [0:STK_DEPTH];
  logic [20:0] rd_ff;

  // write-through keeps the top visible in the cycle after a push
  always_ff @(posedge sys_clk_i) begin
    if (wr_en_i) begin
      mem_ff[wr_addr_i] <= wr_data_i;
    end
    if (wr_en_i && wr_addr_i == rd_addr_i) begin
      rd_ff <= wr_data_i;
    end else begin
      rd_ff <= mem_ff[rd_addr_i];
    end
  end

  assign rd_data_o = rd_ff;
endmodule

// ===== hw/mnsc_exec.sv
// execution unit for multiply, negate, nop, pop, push, relative call and software reset
// Overview of operation
// - literal multiply: accumulator times immediate, unsigned
// - product high and low bytes written
// - multiplies leave every status flag alone
// - file multiply: accumulator times register, operands kept
// - access bit picks access bank or selector
// - extended set, low address: indexed offset
// - negate writes two's complement, sets flags
// - pop discards top, previous entry surfaces
// - push stores pc plus two, one cycle
// - relative call pushes pc plus two
// - call jumps pc+2+2n, second cycle idle
// - software reset equals external pin reset
module mnsc_exec
  import mnsc_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // instruction from decoder
  input  wire logic        instr_valid_i,
  input  wire logic [15:0] instr_i,
  input  wire logic        ext_set_en_i,
  // datapath sources
  input  wire logic [7:0]  accum_i,
  input  wire logic [3:0]  bank_selector_i,
  input  wire logic [11:0] index_base_i,
  input  wire logic [7:0]  file_rd_data_i,
  // file register access
  output logic [11:0]      file_addr_o,
  output logic             file_wr_en_o,
  output logic [7:0]       file_wr_data_o,
  // results
  output logic [7:0]       product_high_byte_o,
  output logic [7:0]       product_low_byte_o,
  output logic [4:0]       status_o,
  output logic [20:0]      pc_o,
  output logic [20:0]      stack_top_entry_o,
  output logic [4:0]       stack_ptr_o,
  output logic             instr_ready_o,
  output logic             external_pin_reset_o
);
  // -------------------------------------------------------------------------
  // decode helpers
  // -------------------------------------------------------------------------
  function automatic logic [11:0] eff_addr(input logic [15:0] ins, input logic ext,
                                           input logic [3:0] bsel, input logic [11:0] base);
    logic [7:0] f;
    f = ins[7:0];
    if (ins[ACC_BIT]) begin
      eff_addr = {bsel, f};
    end else if (ext && f <= IDX_LIMIT) begin
      eff_addr = base + {4'h0, f};
    end else if (f < ACC_SPLIT) begin
      eff_addr = {ACC_HI_BANK, f};
    end else begin
      eff_addr = {SFR_BANK, f};
    end
  endfunction

  function automatic logic [15:0] umul(input logic [7:0] a, input logic [7:0] b);
    umul = {8'h00, a} * {8'h00, b};
  endfunction

  localparam logic [3:0] NIB_ZERO = 4'h0;
  // negate flags: carry means no borrow out of zero minus operand
  function automatic logic [4:0] neg_flags(input logic [7:0] opnd, input logic [7:0] res);
    logic [4:0] flg;
    flg         = STATUS_RESET;
    flg[FLG_N]  = res[7];
    flg[FLG_Z]  = res == BYTE_ZERO;
    flg[FLG_OV] = opnd[7] & res[7];
    flg[FLG_C]  = opnd == BYTE_ZERO;
    flg[FLG_DC] = opnd[3:0] == NIB_ZERO;
    neg_flags   = flg;
  endfunction

  logic is_mullit, is_mulfile, is_neg, is_pop, is_push, is_call, is_rst, is_nop;
  assign is_mullit  = instr_i[15:8] == MULLIT_HI;
  assign is_mulfile = instr_i[15:9] == MULFILE_HI7;
  assign is_neg     = instr_i[15:9] == NEGATE_HI7;
  assign is_pop     = instr_i == POP_OPC;
  assign is_push    = instr_i == PUSH_OPC;
  assign is_call    = instr_i[15:11] == CALL_REL_HI5;
  assign is_rst     = instr_i == SWRST_OPC;
  assign is_nop     = instr_i == NOP_OPC || instr_i[15:12] == NOP2_HI4;

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  mnsc_state_type state_ff, nxt_state;
  logic [7:0]  prod_hi_ff, nxt_prod_hi, prod_lo_ff, nxt_prod_lo;
  logic [4:0]  status_ff, nxt_status;
  logic [20:0] pc_ff, nxt_pc;
  logic [4:0]  sp_ff, nxt_sp;
  logic        stk_wr;
  logic [20:0] stk_wdata;
  logic [4:0]  stk_raddr;
  logic [20:0] stk_rdata;
  logic [7:0]  neg_res;
  logic [15:0] prod;
  logic        fire;

  assign fire      = instr_valid_i && state_ff == MNSC_EXEC_ST;
  assign neg_res   = ~file_rd_data_i + 8'h01;
  assign prod      = umul(accum_i, is_mullit ? instr_i[7:0] : file_rd_data_i);
  assign file_addr_o = eff_addr(instr_i, ext_set_en_i, bank_selector_i, index_base_i);

  always_comb begin
    nxt_state      = state_ff;
    nxt_prod_hi    = prod_hi_ff;
    nxt_prod_lo    = prod_lo_ff;
    nxt_status     = status_ff;
    nxt_pc         = pc_ff;
    nxt_sp         = sp_ff;
    stk_wr         = 1'b0;
    stk_wdata      = pc_ff + PC_STEP;
    file_wr_en_o   = 1'b0;
    file_wr_data_o = neg_res;
    case (state_ff)
      MNSC_EXEC_ST: begin
        if (fire) begin
          nxt_pc = pc_ff + PC_STEP;
          if (is_mullit || is_mulfile) begin
            nxt_prod_hi = prod[15:8];
            nxt_prod_lo = prod[7:0];
          end else if (is_neg) begin
            file_wr_en_o = 1'b1;
            nxt_status   = neg_flags(file_rd_data_i, neg_res);
          end else if (is_pop) begin
            if (sp_ff != SP_ZERO) begin
              nxt_sp = sp_ff - SP_ONE;
            end
          end else if (is_push || is_call) begin
            if (sp_ff != SP_MAX) begin
              nxt_sp = sp_ff + SP_ONE;
              stk_wr = 1'b1;
            end
            if (is_call) begin
              nxt_pc = pc_ff + PC_STEP + {{9{instr_i[10]}}, instr_i[10:0], 1'b0};
              nxt_state = MNSC_FLUSH_ST;
            end
          end else if (is_rst) begin
            nxt_state = MNSC_RST_ST;
          end
        end
      end
      MNSC_FLUSH_ST: begin
        nxt_state = MNSC_EXEC_ST;
      end
      MNSC_RST_ST: begin
        nxt_state = MNSC_EXEC_ST;
      end
      default: begin
        nxt_state = MNSC_EXEC_ST;
      end
    endcase
  end

  // reset instruction reuses the pin-reset values; one reset cycle follows
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || state_ff == MNSC_RST_ST) begin
      state_ff  <= MNSC_EXEC_ST;
      prod_hi_ff <= BYTE_ZERO;
      prod_lo_ff <= BYTE_ZERO;
      status_ff <= STATUS_RESET;
      pc_ff     <= PC_RESET;
      sp_ff     <= SP_ZERO;
    end else begin
      state_ff  <= nxt_state;
      prod_hi_ff <= nxt_prod_hi;
      prod_lo_ff <= nxt_prod_lo;
      status_ff <= nxt_status;
      pc_ff     <= nxt_pc;
      sp_ff     <= nxt_sp;
    end
  end

  assign stk_raddr = nxt_sp;

  mnsc_stack_mem u_stack (
    .sys_clk_i (sys_clk_i),
    .wr_en_i   (stk_wr),
    .wr_addr_i (nxt_sp),
    .wr_data_i (stk_wdata),
    .rd_addr_i (stk_raddr),
    .rd_data_o (stk_rdata)
  );

  // -------------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------------
  assign product_high_byte_o  = prod_hi_ff;
  assign product_low_byte_o   = prod_lo_ff;
  assign status_o             = status_ff;
  assign pc_o                 = pc_ff;
  assign stack_ptr_o          = sp_ff;
  assign stack_top_entry_o    = (sp_ff == SP_ZERO) ? PC_RESET : stk_rdata;
  assign instr_ready_o        = state_ff == MNSC_EXEC_ST;
  assign external_pin_reset_o = state_ff == MNSC_RST_ST;

  // -------------------------------------------------------------------------
  // check helpers
  // -------------------------------------------------------------------------
  // expected values rebuilt from the rules, not taken from the datapath
  localparam logic [7:0] NEG_OVF_VAL = 8'h80;
  logic [7:0]  neg_chk;
  logic [20:0] call_dest;
  assign neg_chk   = 8'(BYTE_ZERO - file_rd_data_i);
  assign call_dest = pc_ff + PC_STEP + 21'($signed({instr_i[10:0], 1'b0}));

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_mul_lit_prod: assert property (fire && is_mullit |=>
    {prod_hi_ff, prod_lo_ff} == 16'($past(accum_i)) * 16'($past(instr_i[7:0]))) else $error("literal product wrong");
  a_mul_pair_write: assert property (fire && is_mulfile |=>
    {prod_hi_ff, prod_lo_ff} == 16'($past(accum_i)) * 16'($past(file_rd_data_i))) else $error("product pair wrong");
  a_mul_flags_kept: assert property (fire && (is_mullit || is_mulfile) |=> $stable(status_ff))
    else $error("multiply changed flags");
  a_mul_file_nowr: assert property (fire && is_mulfile |-> !file_wr_en_o) else $error("multiply wrote file");
  a_bank_sel: assert property (fire && instr_i[ACC_BIT] |-> file_addr_o == {bank_selector_i, instr_i[7:0]})
    else $error("bank select wrong");
  a_idx_mode: assert property (fire && !instr_i[ACC_BIT] && ext_set_en_i && instr_i[7:0] <= IDX_LIMIT
    |-> file_addr_o == index_base_i + {4'h0, instr_i[7:0]}) else $error("indexed address wrong");
  a_neg_value: assert property (fire && is_neg |-> file_wr_en_o &&
    file_wr_data_o == 8'(8'h00 - file_rd_data_i)) else $error("negate wrong");
  a_pop_level: assert property (fire && is_pop && sp_ff != SP_ZERO |=> sp_ff == $past(sp_ff) - SP_ONE)
    else $error("pop level wrong");
  a_push_value: assert property (fire && is_push && sp_ff != SP_MAX |=>
    stack_top_entry_o == $past(pc_ff) + PC_STEP) else $error("push value wrong");
  a_call_push: assert property (fire && is_call && sp_ff != SP_MAX |=>
    sp_ff == $past(sp_ff) + SP_ONE) else $error("call did not push");
  a_call_two_cyc: assert property (fire && is_call |=> !instr_ready_o ##1 instr_ready_o)
    else $error("call not two cycles");
  a_sw_reset: assert property (fire && is_rst |=> external_pin_reset_o ##1
    (pc_o == PC_RESET && stack_ptr_o == SP_ZERO && status_o == STATUS_RESET)) else $error("reset wrong");
  a_nop_quiet: assert property (fire && is_nop |=> $stable(status_ff) && $stable(sp_ff) &&
    pc_ff == $past(pc_ff) + PC_STEP) else $error("nop changed state");
  a_mul_one_cyc: assert property (fire && (is_mullit || is_mulfile) |=>
    instr_ready_o && pc_ff == $past(pc_ff) + PC_STEP && $stable(sp_ff))
    else $error("multiply not one cycle");
  a_access_low: assert property (fire && !instr_i[ACC_BIT] && !ext_set_en_i && instr_i[7:0] < ACC_SPLIT
    |-> file_addr_o == {ACC_HI_BANK, instr_i[7:0]})
    else $error("access bank address wrong");
  a_neg_sign: assert property (fire && is_neg |=>
    status_ff[FLG_N] == $past(neg_chk[7]))
    else $error("negate sign flag wrong");
  a_neg_zero: assert property (fire && is_neg |=>
    status_ff[FLG_Z] == ($past(neg_chk) == BYTE_ZERO))
    else $error("negate zero flag wrong");
  a_neg_carry: assert property (fire && is_neg |=>
    status_ff[FLG_C] == ($past(file_rd_data_i) == BYTE_ZERO))
    else $error("negate carry flag wrong");
  a_neg_ovf: assert property (fire && is_neg |=>
    status_ff[FLG_OV] == ($past(file_rd_data_i) == NEG_OVF_VAL))
    else $error("negate overflow flag wrong");
  a_neg_half: assert property (fire && is_neg |=>
    status_ff[FLG_DC] == ($past(file_rd_data_i[3:0]) == NIB_ZERO))
    else $error("negate half carry flag wrong");
  a_neg_others_kept: assert property (fire && is_neg |=>
    $stable(prod_hi_ff) && $stable(prod_lo_ff) && $stable(sp_ff))
    else $error("negate touched other state");
  a_wr_only_neg: assert property (file_wr_en_o |->
    fire && is_neg)
    else $error("file write outside negate");
  a_pop_one_cyc: assert property (fire && is_pop |=>
    instr_ready_o && pc_ff == $past(pc_ff) + PC_STEP)
    else $error("pop not one cycle");
  a_pop_empty: assert property (fire && is_pop && sp_ff == SP_ZERO |=>
    sp_ff == SP_ZERO)
    else $error("pop of empty stack moved level");
  a_push_level: assert property (fire && is_push && sp_ff != SP_MAX |=>
    sp_ff == $past(sp_ff) + SP_ONE && instr_ready_o)
    else $error("push level wrong");
  a_push_full: assert property (fire && is_push && sp_ff == SP_MAX |=>
    sp_ff == SP_MAX)
    else $error("push on full stack moved level");
  a_call_ret_addr: assert property (fire && is_call && sp_ff != SP_MAX |=>
    stack_top_entry_o == $past(pc_ff) + PC_STEP)
    else $error("call return address wrong");
  a_call_full: assert property (fire && is_call && sp_ff == SP_MAX |=>
    sp_ff == SP_MAX)
    else $error("call on full stack moved level");
  a_call_target: assert property (fire && is_call |=>
    pc_ff == $past(call_dest))
    else $error("call target wrong");
  a_call_idle: assert property (state_ff == MNSC_FLUSH_ST |->
    !file_wr_en_o ##1 ($stable(pc_ff) && $stable(sp_ff) && $stable(status_ff)))
    else $error("call second cycle not idle");
  a_rst_one_cyc: assert property (external_pin_reset_o |=>
    !external_pin_reset_o && instr_ready_o)
    else $error("reset pulse not one cycle");
  a_nop_one_cyc: assert property (fire && is_nop |->
    !file_wr_en_o ##1 (instr_ready_o && $stable(prod_hi_ff) && $stable(prod_lo_ff)))
    else $error("nop not one quiet cycle");
  a_idle_quiet: assert property (state_ff == MNSC_EXEC_ST && !instr_valid_i |=>
    $stable(pc_ff) && $stable(sp_ff) && $stable(status_ff))
    else $error("state moved without instruction");

  c_call: cover property (fire && is_call);
  c_push_pop: cover property (fire && is_push ##1 fire && is_pop);
  c_neg: cover property (fire && is_neg);
  c_reset: cover property (fire && is_rst);
  c_mul_file: cover property (fire && is_mulfile);
endmodule

// ===== dv/mnsc_exec_tb_top.sv
// self-checking testbench for the multiply/negate/stack/call execution unit
module mnsc_exec_tb_top
  import mnsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------------
  logic        sys_clk_i;
  logic        rst_i;
  logic        instr_valid_i;
  logic [15:0] instr_i;
  logic        ext_set_en_i;
  logic [7:0]  accum_i;
  logic [3:0]  bank_selector_i;
  logic [11:0] index_base_i;
  logic [7:0]  file_rd_data_i;
  logic [11:0] file_addr_o;
  logic        file_wr_en_o;
  logic [7:0]  file_wr_data_o;
  logic [7:0]  product_high_byte_o;
  logic [7:0]  product_low_byte_o;
  logic [4:0]  status_o;
  logic [20:0] pc_o;
  logic [20:0] stack_top_entry_o;
  logic [4:0]  stack_ptr_o;
  logic        instr_ready_o;
  logic        external_pin_reset_o;
  int          num_errors;
  int          samples_checked;
  logic [20:0] exp_pc;
  logic [20:0] ret_a;

  mnsc_exec u_mnsc_exec (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .ext_set_en_i(ext_set_en_i), .accum_i(accum_i), .bank_selector_i(bank_selector_i),
    .index_base_i(index_base_i), .file_rd_data_i(file_rd_data_i), .file_addr_o(file_addr_o),
    .file_wr_en_o(file_wr_en_o), .file_wr_data_o(file_wr_data_o),
    .product_high_byte_o(product_high_byte_o), .product_low_byte_o(product_low_byte_o),
    .status_o(status_o), .pc_o(pc_o), .stack_top_entry_o(stack_top_entry_o),
    .stack_ptr_o(stack_ptr_o), .instr_ready_o(instr_ready_o),
    .external_pin_reset_o(external_pin_reset_o)
  );
  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask

  // drive lands on an edge; checks of combinational outputs go between drive and take
  task automatic drive(input logic [15:0] w);
    @(posedge sys_clk_i);
    instr_valid_i <= 1'b1;
    instr_i       <= w;
    #1;
  endtask

  task automatic take();
    @(posedge sys_clk_i);
    instr_valid_i <= 1'b0;
    #1;
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_negate();
    logic [7:0] opnd [3] = '{8'h00, 8'h80, 8'h3A};
    logic [7:0] res  [3] = '{8'h00, 8'h80, 8'hC6};
    logic [4:0] flg  [3] = '{5'h07, 5'h1A, 5'h10};
    for (int i = 0; i < 3; i++) begin
      file_rd_data_i  <= opnd[i];
      bank_selector_i <= 4'h5;
      drive(16'h6D21);
      check(file_addr_o, 32'h0521);
      check(file_wr_en_o, 32'h1);
      check(file_wr_data_o, res[i]);
      take();
      exp_pc = exp_pc + PC_STEP;
      check(status_o, flg[i]);
    end
    $display("test negate done");
  endtask

  task automatic t_mul_lit();
    accum_i <= 8'hE2;
    drive(16'h0DC4);
    take();
    check({product_high_byte_o, product_low_byte_o}, 32'hAD08);
    check(status_o, 32'h10);
    accum_i <= 8'h00;
    drive(16'h0D55);
    take();
    exp_pc = exp_pc + 21'h4;
    check({product_high_byte_o, product_low_byte_o}, 32'h0000);
    check(status_o, 32'h10);
    $display("test literal multiply done");
  endtask

  task automatic t_mul_file();
    logic [15:0] w  [4] = '{16'h0280, 16'h0220, 16'h025F, 16'h0260};
    logic [11:0] ad [4] = '{12'hF80, 12'h020, 12'h35F, 12'hF60};
    accum_i         <= 8'hC4;
    file_rd_data_i  <= 8'hB5;
    bank_selector_i <= 4'h5;
    index_base_i    <= 12'h300;
    drive(16'h0310);
    check(file_addr_o, 32'h0510);
    check(file_wr_en_o, 32'h0);
    take();
    check({product_high_byte_o, product_low_byte_o}, 32'h8A94);
    for (int i = 0; i < 4; i++) begin
      ext_set_en_i <= (i >= 2);
      drive(w[i]);
      check(file_addr_o, ad[i]);
      take();
    end
    ext_set_en_i <= 1'b0;
    exp_pc = exp_pc + 21'hA;
    check(pc_o, exp_pc);
    $display("test file multiply done");
  endtask

  task automatic t_stack();
    ret_a = exp_pc + PC_STEP;
    drive(PUSH_OPC);
    take();
    check(stack_top_entry_o, ret_a);
    drive(PUSH_OPC);
    take();
    check(stack_top_entry_o, ret_a + PC_STEP);
    check(stack_ptr_o, 32'h2);
    drive(POP_OPC);
    take();
    exp_pc = exp_pc + 21'h6;
    check(stack_top_entry_o, ret_a);
    check(stack_ptr_o, 32'h1);
    $display("test stack done");
  endtask

  task automatic t_call(input logic [10:0] n);
    drive({CALL_REL_HI5, n});
    take();
    check(instr_ready_o, 32'h0);
    check(stack_top_entry_o, exp_pc + PC_STEP);
    exp_pc = exp_pc + PC_STEP + {{9{n[10]}}, n, 1'b0};
    check(pc_o, exp_pc);
    $display("test relative call done");
  endtask

  task automatic t_nop();
    logic [4:0] sp;
    sp = stack_ptr_o;
    drive(NOP_OPC);
    check(file_wr_en_o, 32'h0);
    take();
    exp_pc = exp_pc + PC_STEP;
    check(pc_o, exp_pc);
    check(stack_ptr_o, sp);
    check(status_o, 32'h10);
    check({product_high_byte_o, product_low_byte_o}, 32'h8A94);
    $display("test nop done");
  endtask

  task automatic t_swreset();
    drive(SWRST_OPC);
    take();
    check(external_pin_reset_o, 32'h1);
    @(posedge sys_clk_i);
    #1;
    check(external_pin_reset_o, 32'h0);
    check({pc_o, stack_ptr_o, status_o}, 32'h0);
    check({product_high_byte_o, product_low_byte_o}, 32'h0);
    check(instr_ready_o, 32'h1);
    $display("test software reset done");
  endtask
  // ---------------------------------------------------------------------------
  // clock, watchdog and main sequence
  // ---------------------------------------------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  // limit of 20000 cycles; running out is counted as a mismatch
  initial begin
    #2000000;
    num_errors++;
    summarize();
  end

  initial begin
    num_errors = 0;
    samples_checked = 0;
    exp_pc = PC_RESET;
    rst_i = 1'b1;
    instr_valid_i = 1'b0;
    instr_i = NOP_OPC;
    ext_set_en_i = 1'b0;
    accum_i = 8'h00;
    bank_selector_i = 4'h0;
    index_base_i = 12'h000;
    file_rd_data_i = 8'h00;
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_negate();
    t_mul_lit();
    t_mul_file();
    t_stack();
    t_call(11'h400);
    t_call(11'h3FF);
    t_nop();
    t_swreset();
    summarize();
  end
endmodule
